// [design/oepc_consts.svh]
// Overview of operation
// RULE_01: Low three bits of port B drive register set the port 2 drive code.
// RULE_02: Bits five to three set the drive code for reference and half clock pins.
// RULE_03: Software writes zero into reserved bits of drive and low-power registers.
// RULE_04: Output-enable bit 0 drives port A; cleared floats it.
// RULE_05: Output-enable bit 1 drives port B; cleared floats it.
// RULE_06: Output-enable bit 2 drives pixel clock pin; cleared floats it.
// RULE_07: Output-enable bit 3 drives reference, active flag and line clock pins.
// RULE_08: Output-enable bit 4 routes half clock to test-out while TAP sits in reset.
// RULE_09: Latched enable pin gets one extra line clock delay while bit 5 clear.
// RULE_10: Output-enable bit 6 samples enable pin on each rising line clock edge.
// RULE_11: Output-enable bit 7 makes the enable pin ignored entirely.
// RULE_12: Low-power code 00 means normal operation with outputs enabled.
// RULE_13: Codes 01/10/11 float outputs, divide clock by 2/4/8; 11 slows bus.
// RULE_14: Low-power bit 3 selects half clock for test-out, else bit 4 value.
// RULE_15: With low-power bit 3 set, bit 4 sets half clock polarity.
// RULE_16: Low-power bit 5 switches off slicer and resets its registers.
// RULE_17: Group drives only with its enable, code 00 and enable pin permitting.
`ifndef OEPC_CONSTS_SVH
`define OEPC_CONSTS_SVH

`define OEPC_ADDR_LOW_POWER 8'hAA
`define OEPC_ADDR_OUT_ENABLE 8'hF2
`define OEPC_ADDR_DRIVE_B 8'hF9

`define OEPC_RST_LOW_POWER 8'h00
`define OEPC_RST_OUT_ENABLE 8'h00
`define OEPC_RST_DRIVE_B 8'h00

`define OEPC_LP_ACTIVE 2'h0
`define OEPC_LP_DIV2 2'h1
`define OEPC_LP_DIV4 2'h2
`define OEPC_LP_DIV8 2'h3

`define OEPC_DIV2_MASK 3'h1
`define OEPC_DIV4_MASK 3'h3
`define OEPC_DIV8_MASK 3'h7

`endif

// [design/oepc_pkg.sv]
package oepc_pkg;

  typedef struct packed {
    logic pin_ignore;
    logic latch_pin;
    logic no_delay;
    logic half_clock_to_test_out_enable;
    logic ref_en;
    logic pixclk_en;
    logic port_b_en;
    logic port_a_en;
  } oepc_oe_reg_t;

  typedef struct packed {
    logic rsvd7;
    logic timing_sel;
    logic slicer_off;
    logic half_clock_polarity_or_test_bit;
    logic test_out_source_select;
    logic bus_reset;
    logic [1:0] mode;
  } oepc_lp_reg_t;

  typedef struct packed {
    logic [1:0] rsvd;
    logic [2:0] reference_pins_drive_code;
    logic [2:0] port2_drive_code;
  } oepc_drv_reg_t;

  typedef struct packed {
    logic port_a_oe;
    logic port_b_oe;
    logic pixclk_oe;
    logic ref_oe;
    logic half_clk;
    logic tdo;
    logic tdo_oe;
    logic core_tick;
    logic bus_slow;
    logic slicer_rst;
    logic [1:0] clk_div;
    logic [2:0] port2_drive_code;
    logic [2:0] reference_pins_drive_code;
  } oepc_out_t;

  typedef struct packed {
    oepc_oe_reg_t output_enable_register;
    oepc_lp_reg_t power_and_line_clock_control;
    oepc_drv_reg_t port_b_drive_strength;
    logic llc_s1;
    logic llc_s2;
    logic llc_d;
    logic oeq_s1;
    logic oeq_s2;
    logic oeq_lat;
    logic oeq_dly;
    logic half;
    logic [2:0] div_cnt;
    oepc_out_t q;
  } oepc_state_t;

endpackage

// [design/oepc_top.sv]
`timescale 1ns/1ps
`include "oepc_consts.svh"

module oepc_top
  import oepc_pkg::*;
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic nrst_in,
  // Register write port from the serial control bus decoder
  input wire logic wr_strobe_in,
  input wire logic [7:0] wr_addr_in,
  input wire logic [7:0] wr_data_in,
  // Pins and test access port
  input wire logic llc_in,
  input wire logic oe_pin_n_in,
  input wire logic tap_tlr_in,
  input wire logic jtag_tdo_in,
  input wire logic jtag_tdo_oe_in,
  // Pad enables
  output logic port_a_oe_out,
  output logic port_b_oe_out,
  output logic pixclk_oe_out,
  output logic ref_oe_out,
  // Half-rate line clock and test-out pin
  output logic half_rate_line_clock_out,
  output logic tdo_out,
  output logic tdo_oe_out,
  // Pad strengths
  output logic [2:0] port2_drive_code_out,
  output logic [2:0] reference_pins_drive_code_out,
  // Power control
  output logic [1:0] clk_div_out,
  output logic core_tick_out,
  output logic bus_slow_out,
  output logic slicer_rst_out
);

  oepc_state_t st_r;
  oepc_state_t st_nxt;

  function automatic logic grp_drive(input logic en, input logic [1:0] mode,
                                     input logic pin_ok);
    grp_drive = en && (mode == `OEPC_LP_ACTIVE) && pin_ok; // see RULE_17
  endfunction

  function automatic logic [2:0] div_mask(input logic [1:0] mode);
    unique case (mode)
      `OEPC_LP_ACTIVE: div_mask = 3'h0;
      `OEPC_LP_DIV2: div_mask = `OEPC_DIV2_MASK;
      `OEPC_LP_DIV4: div_mask = `OEPC_DIV4_MASK;
      `OEPC_LP_DIV8: div_mask = `OEPC_DIV8_MASK;
    endcase
  endfunction

  logic llc_rise;
  logic oeq_eff_n;
  logic pin_ok;
  logic half_pin;
  logic tdo_route;
  oepc_oe_reg_t oe;
  oepc_lp_reg_t lp;
  oepc_drv_reg_t drv;

  always_comb begin
    st_nxt = st_r;
    oe = st_r.output_enable_register;
    lp = st_r.power_and_line_clock_control;
    drv = st_r.port_b_drive_strength;

    // Register writes; reserved bits are kept but steer nothing
    if (wr_strobe_in) begin
      unique case (wr_addr_in)
        `OEPC_ADDR_OUT_ENABLE: begin
          st_nxt.output_enable_register = wr_data_in;
        end
        `OEPC_ADDR_LOW_POWER: begin
          st_nxt.power_and_line_clock_control = wr_data_in; // see RULE_03
        end
        `OEPC_ADDR_DRIVE_B: begin
          st_nxt.port_b_drive_strength = wr_data_in; // see RULE_03
        end
        default: begin
        end
      endcase
    end

    // Line clock and enable pin come from outside, two stages first
    st_nxt.llc_s1 = llc_in;
    st_nxt.llc_s2 = st_r.llc_s1;
    st_nxt.llc_d = st_r.llc_s2;
    st_nxt.oeq_s1 = oe_pin_n_in;
    st_nxt.oeq_s2 = st_r.oeq_s1;
    llc_rise = st_r.llc_s2 && !st_r.llc_d;

    if (llc_rise) begin
      st_nxt.oeq_lat = st_r.oeq_s2; // see RULE_10
      st_nxt.oeq_dly = st_r.oeq_lat; // see RULE_09
      st_nxt.half = !st_r.half;
    end

    // Pin path: unlatched, latched, or latched plus one line clock
    if (!oe.latch_pin) begin
      oeq_eff_n = st_r.oeq_s2; // see RULE_10
    end else if (oe.no_delay) begin
      oeq_eff_n = st_r.oeq_lat; // see RULE_09
    end else begin
      oeq_eff_n = st_r.oeq_dly; // see RULE_09
    end
    pin_ok = oe.pin_ignore || !oeq_eff_n; // see RULE_11

    // Each group gated by its bit, active mode and the pin
    st_nxt.q.port_a_oe = grp_drive(oe.port_a_en, lp.mode, pin_ok); // see RULE_04
    st_nxt.q.port_b_oe = grp_drive(oe.port_b_en, lp.mode, pin_ok); // see RULE_05
    st_nxt.q.pixclk_oe = grp_drive(oe.pixclk_en, lp.mode, pin_ok); // see RULE_06
    st_nxt.q.ref_oe = grp_drive(oe.ref_en, lp.mode, pin_ok); // see RULE_07 RULE_12 RULE_13

    // Polarity applies only while low-power bit 3 selects the half clock for test-out
    half_pin = st_r.half ^ (lp.test_out_source_select
                            && lp.half_clock_polarity_or_test_bit); // see RULE_15
    st_nxt.q.half_clk = half_pin;

    // Test-out is borrowed only while the TAP sits idle in reset
    tdo_route = tap_tlr_in && oe.half_clock_to_test_out_enable; // see RULE_08
    if (tdo_route) begin
      st_nxt.q.tdo_oe = 1'b1;
      if (lp.test_out_source_select) begin
        st_nxt.q.tdo = half_pin; // see RULE_14
      end else begin
        st_nxt.q.tdo = lp.half_clock_polarity_or_test_bit; // see RULE_14
      end
    end else begin
      st_nxt.q.tdo_oe = jtag_tdo_oe_in;
      st_nxt.q.tdo = jtag_tdo_in;
    end

    st_nxt.q.port2_drive_code = drv.port2_drive_code; // see RULE_01
    st_nxt.q.reference_pins_drive_code = drv.reference_pins_drive_code; // see RULE_02

    // Core tick rate is the divided internal clock
    st_nxt.div_cnt = st_r.div_cnt + 3'h1;
    st_nxt.q.core_tick = ((st_r.div_cnt & div_mask(lp.mode)) == 3'h0); // see RULE_13
    st_nxt.q.clk_div = lp.mode; // see RULE_13
    st_nxt.q.bus_slow = (lp.mode == `OEPC_LP_DIV8); // see RULE_13
    st_nxt.q.slicer_rst = lp.slicer_off; // see RULE_16
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_r <= '0;
      st_r.output_enable_register <= `OEPC_RST_OUT_ENABLE;
      st_r.power_and_line_clock_control <= `OEPC_RST_LOW_POWER;
      st_r.port_b_drive_strength <= `OEPC_RST_DRIVE_B;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign port_a_oe_out = st_r.q.port_a_oe;
  assign port_b_oe_out = st_r.q.port_b_oe;
  assign pixclk_oe_out = st_r.q.pixclk_oe;
  assign ref_oe_out = st_r.q.ref_oe;
  assign half_rate_line_clock_out = st_r.q.half_clk;
  assign tdo_out = st_r.q.tdo;
  assign tdo_oe_out = st_r.q.tdo_oe;
  assign port2_drive_code_out = st_r.q.port2_drive_code;
  assign reference_pins_drive_code_out = st_r.q.reference_pins_drive_code;
  assign clk_div_out = st_r.q.clk_div;
  assign core_tick_out = st_r.q.core_tick;
  assign bus_slow_out = st_r.q.bus_slow;
  assign slicer_rst_out = st_r.q.slicer_rst;

endmodule // oepc_top

// [test/oepc_backend.sv]
`timescale 1ns/1ps
module oepc_backend (
  // Control
  input wire logic mclk_in,
  input wire logic run_in,
  // Line clock toward the device, still while not running
  output logic llc_out
);
  logic [1:0] cnt_r = 2'h0;
  initial llc_out = 1'b0;
  always @(posedge mclk_in) begin
    if (run_in) begin
      cnt_r <= (cnt_r == 2'h2) ? 2'h0 : cnt_r + 2'h1;
      if (cnt_r == 2'h2) llc_out <= !llc_out;
    end
  end
endmodule // oepc_backend

// [test/oepc_props.sv]
`timescale 1ns/1ps
module oepc_props (
  // Clock, reset and write port
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic wr_strobe_in,
  input wire logic [7:0] wr_addr_in,
  input wire logic [7:0] wr_data_in,
  // Test access port
  input wire logic tap_tlr_in,
  input wire logic jtag_tdo_in,
  // Observed outputs
  input wire logic port_a_oe_out,
  input wire logic port_b_oe_out,
  input wire logic pixclk_oe_out,
  input wire logic ref_oe_out,
  input wire logic tdo_out,
  input wire logic [2:0] port2_drive_code_out,
  input wire logic [2:0] reference_pins_drive_code_out,
  input wire logic [1:0] clk_div_out,
  input wire logic core_tick_out,
  input wire logic bus_slow_out,
  input wire logic slicer_rst_out
);
  logic w_f9;
  logic w_f2;
  logic w_aa;
  assign w_f9 = wr_strobe_in && wr_addr_in == 8'hF9;
  assign w_f2 = wr_strobe_in && wr_addr_in == 8'hF2;
  assign w_aa = wr_strobe_in && wr_addr_in == 8'hAA;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  property p_drv2; w_f9 |-> ##2 port2_drive_code_out == $past(wr_data_in[2:0], 2); endproperty
  a_drv2: assert property (p_drv2) else $error("port2 drive code wrong");
  property p_drvr; w_f9 |-> ##2 reference_pins_drive_code_out == $past(wr_data_in[5:3], 2); endproperty
  a_drvr: assert property (p_drvr) else $error("reference drive code wrong");
  property p_aoff; w_f2 && !wr_data_in[0] |-> ##2 !port_a_oe_out; endproperty
  a_aoff: assert property (p_aoff) else $error("port a driven while disabled");
  property p_boff; w_f2 && !wr_data_in[1] |-> ##2 !port_b_oe_out; endproperty
  a_boff: assert property (p_boff) else $error("port b driven while disabled");
  property p_lpoff; clk_div_out != 2'h0 |-> !(port_a_oe_out || port_b_oe_out || pixclk_oe_out || ref_oe_out); endproperty
  a_lpoff: assert property (p_lpoff) else $error("outputs driven in low power");
  property p_slow; w_aa |-> ##2 bus_slow_out == ($past(wr_data_in[1:0], 2) == 2'h3); endproperty
  a_slow: assert property (p_slow) else $error("bus slow flag wrong");
  property p_tick; core_tick_out && clk_div_out == 2'h1 |=> !core_tick_out || clk_div_out != 2'h1; endproperty
  a_tick: assert property (p_tick) else $error("tick too frequent");
  property p_slc; w_aa |-> ##2 slicer_rst_out == $past(wr_data_in[5], 2); endproperty
  a_slc: assert property (p_slc) else $error("slicer reset wrong");
  property p_tdo; $past(!tap_tlr_in) |-> tdo_out == $past(jtag_tdo_in); endproperty
  a_tdo: assert property (p_tdo) else $error("test out not passed through");
endmodule // oepc_props
bind oepc_top oepc_props u_oepc_props (.*);

// [test/oepc_top_tb_top.sv]
`timescale 1ns/1ps
module oepc_top_tb_top;
  logic mclk_in = 0, nrst_in = 0, wr_strobe_in = 0, oe_pin_n_in = 0, tap_tlr_in = 0, jtag_tdo_in = 0, run = 0;
  logic jtag_tdo_oe_in = 0, llc_in, port_a_oe_out, port_b_oe_out, pixclk_oe_out, ref_oe_out, tdo_out, tdo_oe_out;
  logic half_rate_line_clock_out, core_tick_out, bus_slow_out, slicer_rst_out, h;
  logic [7:0] wr_addr_in = 8'h00, wr_data_in = 8'h00;
  logic [2:0] port2_drive_code_out, reference_pins_drive_code_out;
  logic [1:0] clk_div_out;
  int error_cnt = 0, comparisons = 0, n;
  logic [19:0] rows [8] = '{20'h000FF, 20'h00018, 20'h00024, 20'h00042, 20'h00081, 20'h010F0, 20'h020F0, 20'h030F0};
  oepc_top u_oepc_top (.*);
  oepc_backend u_oepc_backend (.mclk_in(mclk_in), .run_in(run), .llc_out(llc_in));
  initial forever #2 mclk_in = ~mclk_in;
  task chk(input string s, input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", s, exp, got);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in); #1;
    wr_strobe_in = 1;
    wr_addr_in = a;
    wr_data_in = d;
    @(posedge mclk_in); #1;
    wr_strobe_in = 0;
  endtask
  task cyc(input int k);
    repeat (k) @(posedge mclk_in);
    #1;
  endtask
  task summarize;
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    cyc(20);
    chk("reset oe", {port_a_oe_out, port_b_oe_out, pixclk_oe_out, ref_oe_out}, 8'h00);
    nrst_in = 1;
    foreach (rows[i]) begin
      wr(8'hAA, rows[i][19:12]);
      wr(8'hF2, rows[i][11:4]);
      cyc(4);
      chk("oe", {port_a_oe_out, port_b_oe_out, pixclk_oe_out, ref_oe_out}, rows[i][3:0]);
      chk("div", clk_div_out, rows[i][13:12]);
      chk("slow", bus_slow_out, rows[i][13:12] == 2'h3);
    end
    n = 0;
    repeat (16) begin
      cyc(1);
      n += core_tick_out;
    end
    chk("tick", n, 8'h02);
    wr(8'hAA, 8'h00);
    wr(8'hF9, 8'h2B);
    wr(8'h55, 8'hFF);
    cyc(4);
    chk("drv2", port2_drive_code_out, 8'h03);
    chk("drvr", reference_pins_drive_code_out, 8'h05);
    chk("unmapped", {port_a_oe_out, ref_oe_out}, 8'h03);
    oe_pin_n_in = 1;
    cyc(4);
    chk("pin off", {port_a_oe_out, ref_oe_out}, 8'h00);
    wr(8'hF2, 8'h8F);
    cyc(4);
    chk("pin ignored", {port_a_oe_out, ref_oe_out}, 8'h03);
    oe_pin_n_in = 0;
    run = 1;
    wr(8'hF2, 8'h4F);
    cyc(30);
    run = 0;
    cyc(8);
    oe_pin_n_in = 1;
    cyc(10);
    chk("latched hold", port_a_oe_out, 8'h01);
    run = 1;
    for (n = 0; n < 40 && port_a_oe_out !== 1'b0; n++) cyc(1);
    chk("latched off", port_a_oe_out, 8'h00);
    if (n == 40) summarize();
    oe_pin_n_in = 0;
    tap_tlr_in = 1;
    jtag_tdo_in = 1;
    wr(8'hF2, 8'h10);
    wr(8'hAA, 8'h10);
    cyc(4);
    chk("tdo bit", {tdo_oe_out, tdo_out}, 8'h03);
    wr(8'hAA, 8'h08);
    n = 0;
    repeat (40) begin
      cyc(1);
      n += tdo_out;
      chk("tdo half", tdo_out, half_rate_line_clock_out);
    end
    chk("tdo clock", n > 0 && n < 40, 8'h01);
    run = 0;
    cyc(8);
    h = half_rate_line_clock_out;
    wr(8'hAA, 8'h18);
    cyc(4);
    chk("half polarity", half_rate_line_clock_out, {7'h00, ~h});
    tap_tlr_in = 0;
    wr(8'hAA, 8'h20);
    cyc(4);
    chk("tdo pass", tdo_out, 8'h01);
    chk("slicer", slicer_rst_out, 8'h01);
    summarize();
  end
endmodule // oepc_top_tb_top
